// ---- scca_map.svh ----
/*
 * Register offsets, field positions, reset values and timing counts of the
 * shared counter array. Assumes APB byte addressing, one register per word.
 */
`ifndef SCCA_MAP_SVH
`define SCCA_MAP_SVH

`define SCCA_OFF_CTRL_STAT  12'h000
`define SCCA_OFF_MODE_CFG   12'h004
`define SCCA_OFF_COUNT_LOW  12'h008
`define SCCA_OFF_COUNT_HIGH 12'h00C
`define SCCA_OFF_MOD_BASE   12'h010
`define SCCA_MOD_STRIDE     12'h00C
`define SCCA_MOD_MODE       12'h000
`define SCCA_MOD_VLOW       12'h004
`define SCCA_MOD_VHIGH      12'h008

`define SCCA_CS_RUN         6
`define SCCA_CS_OVF         7
`define SCCA_MC_IDLE_STOP   7
`define SCCA_MC_WDT_EN      6
`define SCCA_MC_SEL_HI      2
`define SCCA_MC_SEL_LO      1
`define SCCA_MC_OVF_IE      0

`define SCCA_MM_CMP_EN      6
`define SCCA_MM_CAP_RISE    5
`define SCCA_MM_CAP_FALL    4
`define SCCA_MM_MATCH       3
`define SCCA_MM_TOGGLE      2
`define SCCA_MM_PWM         1
`define SCCA_MM_IRQ_EN      0

`define SCCA_RESET_BYTE     8'h00
`define SCCA_PHASE_COUNT    12
`define SCCA_PH_S1P2        4'h1
`define SCCA_PH_S3P2        4'h5
`define SCCA_PH_PHASE_FIVE_P2        4'h9
`define SCCA_HIGH_DELAY     2

`endif

// ---- scca_pkg.sv ----
/*
 * Types shared by the counter array files.
 * Assumes the map header supplies all numeric constants.
 */
`default_nettype none
package scca_pkg;
    typedef enum logic [1:0] {
        SCCA_IN_DIV12 = 2'h0,
        SCCA_IN_DIV4  = 2'h1,
        SCCA_IN_T0OVF = 2'h2,
        SCCA_IN_EXT   = 2'h3
    } scca_insel_t;
endpackage
`default_nettype wire

// ---- scca_module.sv ----
/*
 * One compare/capture module: capture, software timer, high-speed output,
 * PWM, watchdog. Assumes synchronised pin input and one-cycle sample strobes.
 */
`default_nettype none
`include "scca_map.svh"
module scca_module #(
    parameter bit HAS_WDT = 1'b0
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_sample,
    input  wire logic        i_running,
    input  wire logic [15:0] i_count,
    input  wire logic        i_rollover,
    input  wire logic        i_pin_sync,
    input  wire logic        i_wr_mode,
    input  wire logic        i_wr_low,
    input  wire logic        i_wr_high,
    input  wire logic        i_wr_flag,
    input  wire logic [7:0]  i_wdata,
    output logic [6:0]       o_mode,
    output logic [7:0]       o_low,
    output logic [7:0]       o_high,
    output logic             o_flag,
    output logic             o_pin,
    output logic             o_wdt_match
);
    logic       pin_prev;
    logic       next_flag;
    wire  logic cmp_en    = o_mode[`SCCA_MM_CMP_EN];
    wire  logic rise_sel  = o_mode[`SCCA_MM_CAP_RISE];
    wire  logic fall_sel  = o_mode[`SCCA_MM_CAP_FALL];
    wire  logic mat       = o_mode[`SCCA_MM_MATCH];
    wire  logic tog       = o_mode[`SCCA_MM_TOGGLE];
    wire  logic pwm       = o_mode[`SCCA_MM_PWM];
    wire  logic act       = i_sample && i_running;
    wire  logic rise_ev   = rise_sel && i_pin_sync && !pin_prev;
    wire  logic fall_ev   = fall_sel && !i_pin_sync && pin_prev;
    wire  logic cap_ev    = act && !cmp_en && (rise_ev || fall_ev);
    wire  logic m16       = i_count == {o_high, o_low};
    wire  logic m8        = i_count[7:0] == o_low;
    wire  logic cmp_ev    = act && cmp_en && mat && !pwm && m16;
    wire  logic pwm_on    = cmp_en && pwm && !mat;
    wire  logic sw_tmr    = cmp_en && mat && !tog && !pwm;

    assign next_flag = (o_flag && !(i_wr_flag && !i_wdata[0])) || cap_ev || cmp_ev;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pin_prev <= 1'b1;
            o_mode   <= 7'h00;
            o_low    <= `SCCA_RESET_BYTE;
            o_high   <= `SCCA_RESET_BYTE;
            o_flag   <= 1'b0;
            o_pin    <= 1'b1;
            o_wdt_match <= 1'b0;
        end else begin
            o_flag <= next_flag;
            if (i_sample) begin
                pin_prev <= i_pin_sync;
            end
            // Compare enable: low-byte write clears and high-byte write sets in timer mode
            if (i_wr_mode) begin
                o_mode <= i_wdata[6:0];
            end else if (sw_tmr && i_wr_low) begin
                o_mode[`SCCA_MM_CMP_EN] <= 1'b0;
            end else if (o_mode[`SCCA_MM_MATCH] && !pwm && i_wr_high) begin
                o_mode[`SCCA_MM_CMP_EN] <= 1'b1;
            end
            // Capture overwrites any unread value
            if (cap_ev) begin
                {o_high, o_low} <= i_count;
            end else begin
                if (i_wr_low) begin
                    o_low <= i_wdata;
                end else if (act && pwm_on && i_rollover) begin
                    o_low <= o_high;
                end
                if (i_wr_high) begin
                    o_high <= i_wdata;
                end
            end
            if (cmp_ev && tog) begin
                o_pin <= !o_pin;
            end else if (act && pwm_on) begin
                // Level form: low below the compare byte, high from match to rollover
                o_pin <= m8 || i_count[7:0] > o_low;
            end else if (!cmp_en) begin
                o_pin <= 1'b1;
            end
            o_wdt_match <= HAS_WDT && cmp_ev && !tog;
        end
    end
endmodule
`default_nettype wire

// ---- scca_top.sv ----
/*
 * Shared-time-base counter array: 16-bit counter, input selection, run and
 * idle gating, five compare/capture modules, APB register slave.
 * Assumes pins are asynchronous, timer 0 overflow and idle are on I_SYS_CLK.
 */
// Added by the designer: the placing of the registers and the APB slave port.
`default_nettype none
`include "scca_map.svh"
module scca_top #(
    parameter int NUM_MOD = 5
) (
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_RST_N,
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [11:0] I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    input  wire logic        I_TIMER0_OVF,
    input  wire logic        I_IDLE,
    input  wire logic        I_COUNT_GATE,
    input  wire logic        I_EXTERNAL_COUNT_PIN,
    input  wire logic [4:0]  I_MODULE_IO_PIN,
    output logic [31:0]      O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    output logic [4:0]       O_MODULE_IO_PIN,
    output logic             O_IRQ,
    output logic             O_WDT_RESET
);
    logic [3:0]  phase;
    logic [7:0]  count_low_byte;
    logic [7:0]  count_high_byte;
    logic        counter_overflow_flag;
    logic        counter_run;
    logic [7:0]  counter_mode_config;
    logic [1:0]  high_pend;
    logic        ext_meta;
    logic        ext_sync;
    logic        ext_prev;
    logic        ext_fall_seen;
    logic        t0_seen;
    logic [4:0]  pin_meta;
    logic [4:0]  pin_sync;
    logic [6:0]  mode_q  [NUM_MOD];
    logic [7:0]  low_q   [NUM_MOD];
    logic [7:0]  high_q  [NUM_MOD];
    logic [4:0]  flag_q;
    logic [4:0]  pin_q;
    logic [4:0]  wdt_q;
    logic [31:0] next_prdata;

    wire logic         s1 = phase == `SCCA_PH_S1P2;
    wire logic         s3 = phase == `SCCA_PH_S3P2;
    wire logic         s5 = phase == `SCCA_PH_PHASE_FIVE_P2;
    wire logic         sample3 = s1 || s3 || s5;
    wire scca_pkg::scca_insel_t insel =
        scca_pkg::scca_insel_t'({counter_mode_config[`SCCA_MC_SEL_HI],
                                 counter_mode_config[`SCCA_MC_SEL_LO]});
    wire logic idle_block = I_IDLE && counter_mode_config[`SCCA_MC_IDLE_STOP];
    wire logic running    = counter_run && I_COUNT_GATE && !idle_block;
    wire logic t0_now     = I_TIMER0_OVF || t0_seen;
    wire logic ext_fall   = ext_prev && !ext_sync;

    logic tick;
    always_comb begin
        case (insel)
            scca_pkg::SCCA_IN_DIV12: tick = s5;
            scca_pkg::SCCA_IN_DIV4:  tick = sample3;
            scca_pkg::SCCA_IN_T0OVF: tick = s5 && t0_now;
            default:                 tick = sample3 && (ext_fall || ext_fall_seen);
        endcase
    end
    wire logic inc      = tick && running;
    wire logic low_ovf  = inc && count_low_byte == 8'hFF;
    wire logic rollover = low_ovf; // Reload only on a real FF to 00 step
    wire logic high_ovf = high_pend[1] && count_high_byte == 8'hFF;

    // APB decode
    wire logic       acc   = I_PSEL && I_PENABLE;
    wire logic       wr    = acc && I_PWRITE;
    wire logic [11:0] mrel = I_PADDR - `SCCA_OFF_MOD_BASE;
    wire logic       in_mod = I_PADDR >= `SCCA_OFF_MOD_BASE &&
                              mrel < 12'(NUM_MOD) * `SCCA_MOD_STRIDE;
    wire logic [11:0] midx = mrel / `SCCA_MOD_STRIDE;
    wire logic [11:0] mreg = mrel - midx * `SCCA_MOD_STRIDE;
    wire logic       hit_cs  = I_PADDR == `SCCA_OFF_CTRL_STAT;
    wire logic       hit_mc  = I_PADDR == `SCCA_OFF_MODE_CFG;
    wire logic       hit_cl  = I_PADDR == `SCCA_OFF_COUNT_LOW;
    wire logic       hit_ch  = I_PADDR == `SCCA_OFF_COUNT_HIGH;
    wire logic       mapped  = (hit_cs || hit_mc || hit_cl || hit_ch || in_mod) &&
                               I_PADDR[1:0] == 2'h0;
    wire logic       wr_cs   = wr && hit_cs;
    wire logic       mod_irq = |(flag_q & {mode_q[4][0], mode_q[3][0], mode_q[2][0],
                                           mode_q[1][0], mode_q[0][0]});

    always_comb begin
        next_prdata = 32'h0000_0000;
        if (hit_cs) begin
            next_prdata[7:0] = {counter_overflow_flag, counter_run, 1'b0, flag_q};
        end else if (hit_mc) begin
            next_prdata[7:0] = counter_mode_config;
        end else if (hit_cl) begin
            next_prdata[7:0] = count_low_byte;
        end else if (hit_ch) begin
            next_prdata[7:0] = count_high_byte;
        end else if (in_mod && mreg == `SCCA_MOD_MODE) begin
            next_prdata[6:0] = mode_q[midx[2:0]];
        end else if (in_mod && mreg == `SCCA_MOD_VLOW) begin
            next_prdata[7:0] = low_q[midx[2:0]];
        end else if (in_mod && mreg == `SCCA_MOD_VHIGH) begin
            next_prdata[7:0] = high_q[midx[2:0]];
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_MOD; g++) begin : gen_mod
            wire logic       sel  = wr && in_mod && midx == 12'(g);
            // Status writes carry one flag bit per module, other writes a whole byte
            wire logic [7:0] wdat = hit_cs ? {I_PWDATA[7:1], I_PWDATA[g]} : I_PWDATA[7:0];
            scca_module #(.HAS_WDT(g == 4)) u_mod (
                .i_clk       (I_SYS_CLK),
                .i_rst_n     (I_RST_N),
                .i_sample    (sample3),
                .i_running   (running),
                .i_count     ({count_high_byte, count_low_byte}),
                .i_rollover  (rollover),
                .i_pin_sync  (pin_sync[g]),
                .i_wr_mode   (sel && mreg == `SCCA_MOD_MODE),
                .i_wr_low    (sel && mreg == `SCCA_MOD_VLOW),
                .i_wr_high   (sel && mreg == `SCCA_MOD_VHIGH),
                .i_wr_flag   (wr_cs),
                .i_wdata     (wdat),
                .o_mode      (mode_q[g]),
                .o_low       (low_q[g]),
                .o_high      (high_q[g]),
                .o_flag      (flag_q[g]),
                .o_pin       (pin_q[g]),
                .o_wdt_match (wdt_q[g])
            );
        end
    endgenerate

    // Pin synchronisers; first stage feeds only the second
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            ext_meta <= 1'b1;
            ext_sync <= 1'b1;
            pin_meta <= 5'h1F;
            pin_sync <= 5'h1F;
        end else begin
            ext_meta <= I_EXTERNAL_COUNT_PIN;
            ext_sync <= ext_meta;
            pin_meta <= I_MODULE_IO_PIN;
            pin_sync <= pin_meta;
        end
    end

    // Peripheral cycle phase generator: twelve oscillator clocks
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            phase <= 4'h0;
        end else if (phase == 4'(`SCCA_PHASE_COUNT - 1)) begin
            phase <= 4'h0;
        end else begin
            phase <= phase + 4'h1;
        end
    end

    // Remember timer 0 overflow and pin falls until the next counting phase
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            t0_seen       <= 1'b0;
            ext_prev      <= 1'b1;
            ext_fall_seen <= 1'b0;
        end else begin
            ext_prev <= ext_sync;
            // Cleared once consumed, so a late overflow is carried, not lost
            if (s5) begin
                t0_seen <= 1'b0;
            end else if (I_TIMER0_OVF) begin
                t0_seen <= 1'b1;
            end
            if (sample3) begin
                ext_fall_seen <= 1'b0;
            end else if (ext_fall) begin
                ext_fall_seen <= 1'b1;
            end
        end
    end

    // Counter bytes; software writes blocked while counter_run is set, even when gate or idle stops counting
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            count_low_byte  <= `SCCA_RESET_BYTE;
            count_high_byte <= `SCCA_RESET_BYTE;
            high_pend       <= 2'h0;
        end else begin
            high_pend <= {high_pend[0], low_ovf};
            if (wr && hit_cl && !counter_run) begin
                count_low_byte <= I_PWDATA[7:0];
            end else if (inc) begin
                count_low_byte <= count_low_byte + 8'h01;
            end
            if (wr && hit_ch && !counter_run) begin
                count_high_byte <= I_PWDATA[7:0];
            end else if (high_pend[1]) begin
                count_high_byte <= count_high_byte + 8'h01;
            end
        end
    end

    // Control registers and overflow flag; hardware set wins over clear
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            counter_run           <= 1'b0;
            counter_overflow_flag <= 1'b0;
            counter_mode_config   <= `SCCA_RESET_BYTE;
        end else begin
            if (wr_cs) begin
                counter_run <= I_PWDATA[`SCCA_CS_RUN];
            end
            if (high_ovf) begin
                counter_overflow_flag <= 1'b1;
            end else if (wr_cs && !I_PWDATA[`SCCA_CS_OVF]) begin
                counter_overflow_flag <= 1'b0;
            end
            if (wr && hit_mc) begin
                counter_mode_config <= I_PWDATA[7:0];
            end
        end
    end

    // Registered outputs
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            O_PRDATA        <= 32'h0000_0000;
            O_PREADY        <= 1'b0;
            O_PSLVERR       <= 1'b0;
            O_MODULE_IO_PIN <= 5'h1F;
            O_IRQ           <= 1'b0;
            O_WDT_RESET     <= 1'b0;
        end else begin
            O_PREADY        <= I_PSEL && !I_PENABLE;
            O_PSLVERR       <= I_PSEL && !I_PENABLE && !mapped;
            O_PRDATA        <= (I_PSEL && !I_PENABLE && !I_PWRITE) ? next_prdata
                                                                  : 32'h0000_0000;
            O_MODULE_IO_PIN <= pin_q;
            O_IRQ           <= (counter_overflow_flag &&
                                counter_mode_config[`SCCA_MC_OVF_IE]) || mod_irq;
            O_WDT_RESET     <= wdt_q[4] && counter_mode_config[`SCCA_MC_WDT_EN];
        end
    end
endmodule
`default_nettype wire

// ---- scca_chk.sv ----
/* Port checker for the counter array top: APB timing, reset outputs,
   watchdog pulse. Assumes one clock and the bind at the foot. */
`default_nettype none
module scca_chk #(
    parameter int NUM_MOD = 5
) (
    input wire logic        I_SYS_CLK,
    input wire logic        I_RST_N,
    input wire logic        I_PSEL,
    input wire logic        I_PENABLE,
    input wire logic        I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic        I_TIMER0_OVF,
    input wire logic        I_IDLE,
    input wire logic        I_COUNT_GATE,
    input wire logic        I_EXTERNAL_COUNT_PIN,
    input wire logic [4:0]  I_MODULE_IO_PIN,
    input wire logic [31:0] O_PRDATA,
    input wire logic        O_PREADY,
    input wire logic        O_PSLVERR,
    input wire logic [4:0]  O_MODULE_IO_PIN,
    input wire logic        O_IRQ,
    input wire logic        O_WDT_RESET
);
    timeunit 1ns;
    timeprecision 1ps;
    // First word past the last module block
    localparam int top_addr = 16 + 12 * NUM_MOD;
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_N);
    sequence s_setup;
        I_PSEL && !I_PENABLE;
    endsequence
    sequence s_bad;
        s_setup ##0 (I_PADDR >= top_addr || I_PADDR[1:0] != 2'h0);
    endsequence
    sequence s_good;
        s_setup ##0 (I_PADDR < top_addr && I_PADDR[1:0] == 2'h0);
    endsequence
    a_ready_after: assert property (s_setup |=> O_PREADY)
        else $error("pready missing after setup");
    a_ready_access: assert property (O_PREADY |-> I_PSEL && I_PENABLE)
        else $error("pready outside access phase");
    a_ready_single: assert property (O_PREADY |=> !O_PREADY)
        else $error("pready longer than one cycle");
    a_err_unmapped: assert property (s_bad |=> O_PSLVERR && O_PREADY)
        else $error("no error for unmapped address");
    a_err_mapped: assert property (s_good |=> !O_PSLVERR)
        else $error("error for mapped address");
    a_data_idle: assert property (!O_PREADY |-> O_PRDATA == 32'h00000000)
        else $error("read data outside access");
    a_data_byte: assert property (O_PREADY |-> O_PRDATA[31:8] == 24'h000000)
        else $error("read data above byte");
    a_wdt_single: assert property (O_WDT_RESET |=> !O_WDT_RESET)
        else $error("watchdog reset longer than one cycle");
    // Checked during reset too, so the default disable is overridden
    a_reset_outs: assert property (disable iff (1'b0)
        !I_RST_N |=> O_MODULE_IO_PIN == 5'h1F && !O_IRQ && !O_WDT_RESET)
        else $error("outputs not at reset values");
endmodule
bind scca_top scca_chk #(.NUM_MOD(NUM_MOD)) i_chk (
    .I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
    .I_PWDATA(I_PWDATA), .I_TIMER0_OVF(I_TIMER0_OVF), .I_IDLE(I_IDLE),
    .I_COUNT_GATE(I_COUNT_GATE), .I_EXTERNAL_COUNT_PIN(I_EXTERNAL_COUNT_PIN),
    .I_MODULE_IO_PIN(I_MODULE_IO_PIN), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
    .O_PSLVERR(O_PSLVERR), .O_MODULE_IO_PIN(O_MODULE_IO_PIN), .O_IRQ(O_IRQ),
    .O_WDT_RESET(O_WDT_RESET)
);
`default_nettype wire

// ---- scca_pin_model.sv ----
/* Far-side pins: external count pin and module capture pins.
   Assumes calls from the bench right after a rising edge. */
`default_nettype none
module scca_pin_model (
    input  wire logic       i_clk,
    output var  logic       o_count_pin,
    output var  logic [4:0] o_mod_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // Count pin idles high so no false fall at start
    initial begin
        o_count_pin = 1'b1;
        o_mod_pins  = 5'h00;
    end
    // Eight clocks per level keeps the rate at or below clk/8
    task automatic falls(input int n);
        repeat (n) begin
            repeat (8) @(posedge i_clk);
            o_count_pin <= 1'b0;
            repeat (8) @(posedge i_clk);
            o_count_pin <= 1'b1;
        end
    endtask
    task automatic set_pin(input int k, input logic v);
        o_mod_pins[k] <= v;
    endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
/* Self-checking bench for the counter array top, one task per scenario.
   Assumes scca_pin_model drives the pins and zero-wait APB answers. */
`default_nettype none
`include "scca_map.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] ad_cs = `SCCA_OFF_CTRL_STAT;
    localparam logic [11:0] ad_mc = `SCCA_OFF_MODE_CFG;
    localparam logic [11:0] ad_cl = `SCCA_OFF_COUNT_LOW;
    localparam logic [11:0] ad_ch = `SCCA_OFF_COUNT_HIGH;
    logic        clk, rst_n, psel, penable, pwrite, t0, idle, gate;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, irq, wdt, cnt_pin;
    logic [4:0]  pins_i, pins_o;
    int          n_mismatch, comparisons;
    wire logic [6:0] obs = {wdt, irq, pins_o};
    `define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
        $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
    scca_top i_scca_top (
        .I_SYS_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_TIMER0_OVF(t0),
        .I_IDLE(idle), .I_COUNT_GATE(gate), .I_EXTERNAL_COUNT_PIN(cnt_pin),
        .I_MODULE_IO_PIN(pins_i), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .O_MODULE_IO_PIN(pins_o), .O_IRQ(irq), .O_WDT_RESET(wdt)
    );
    scca_pin_model i_scca_pin_model (.i_clk(clk), .o_count_pin(cnt_pin), .o_mod_pins(pins_i));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic test_done();
        $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Idle cycle after release avoids two assignments in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                       output logic [7:0] r, output logic e);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        r = prdata[7:0];
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic       e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] r);
        logic e;
        apb(1'b0, a, 8'h00, r, e);
    endtask
    function automatic logic [11:0] ma(input int n, input logic [11:0] off);
        return `SCCA_OFF_MOD_BASE + `SCCA_MOD_STRIDE * n[11:0] + off;
    endfunction
    // Bit k of {wdt, irq, pins_o} reaches lvl within a bound
    task automatic wait_on(input int k, input logic lvl);
        int n;
        n = 0;
        while (obs[k] !== lvl && n < 3000) begin
            n++;
            @(posedge clk);
        end
        `CHK(obs[k], lvl);
    endtask
    task automatic t_reset();
        logic [7:0] v;
        logic       e;
        apb(1'b0, 12'h0FC, 8'h00, v, e);
        `CHK(e, 1'b1);
        for (int a = 0; a < 19; a++) begin
            rd(12'(a * 4), v);
            `CHK(v, `SCCA_RESET_BYTE);
        end
        `CHK({irq, pins_o}, 6'h1F);
    endtask
    // Run window is exactly 120 clocks: 10, 30, 4 pulses, 5 falls
    task automatic t_rates();
        logic [7:0] v;
        logic [7:0] exp_c [4];
        exp_c = '{8'h0A, 8'h1E, 8'h04, 8'h05};
        for (int s = 0; s < 4; s++) begin
            wr(ad_cl, 8'h00);
            wr(ad_ch, 8'h00);
            wr(ad_mc, {5'h00, s[1:0], 1'b0});
            wr(ad_cs, 8'h40);
            fork
                begin
                    repeat (50) @(posedge clk);
                    wr(ad_cl, 8'h55);
                    repeat (64) @(posedge clk);
                    wr(ad_cs, 8'h00);
                end
                if (s == 2) begin
                    repeat (20) @(posedge clk);
                    repeat (4) begin
                        t0 <= 1'b1;
                        @(posedge clk);
                        t0 <= 1'b0;
                        repeat (23) @(posedge clk);
                    end
                end else if (s == 3) i_scca_pin_model.falls(5);
            join
            rd(ad_cl, v);
            `CHK(v, exp_c[s]);
        end
    endtask
    task automatic t_gate();
        logic [7:0] v;
        wr(ad_cl, 8'h00);
        wr(ad_mc, 8'h82);
        gate <= 1'b0;
        wr(ad_cs, 8'h40);
        repeat (40) @(posedge clk);
        rd(ad_cl, v);
        `CHK(v, 8'h00);
        gate <= 1'b1;
        idle <= 1'b1;
        repeat (40) @(posedge clk);
        rd(ad_cl, v);
        `CHK(v, 8'h00);
        idle <= 1'b0;
        repeat (40) @(posedge clk);
        rd(ad_cl, v);
        `CHK(v != 8'h00, 1'b1);
        wr(ad_cs, 8'h00);
    endtask
    task automatic t_ovf();
        logic [7:0] v;
        wr(ad_cl, 8'hF0);
        wr(ad_ch, 8'hFF);
        wr(ad_mc, 8'h03);
        wr(ad_cs, 8'h40);
        wait_on(5, 1'b1);
        rd(ad_cs, v);
        `CHK(v, 8'hC0);
        rd(ad_ch, v);
        `CHK(v, 8'h00);
        wr(ad_cs, 8'hC0);
        rd(ad_cs, v);
        `CHK(v, 8'hC0);
        wr(ad_cs, 8'h40);
        rd(ad_cs, v);
        `CHK({v, irq}, 9'h080);
        wr(ad_cs, 8'h00);
    endtask
    task automatic t_cap();
        logic [7:0] v;
        logic [7:0] c1;
        wr(ma(0, `SCCA_MOD_MODE), 8'h11);
        wr(ad_cl, 8'h00);
        wr(ad_ch, 8'h00);
        wr(ad_mc, 8'h02);
        wr(ad_cs, 8'h40);
        i_scca_pin_model.set_pin(0, 1'b1);
        repeat (40) @(posedge clk);
        rd(ad_cs, v);
        `CHK(v, 8'h40);
        i_scca_pin_model.set_pin(0, 1'b0);
        wait_on(5, 1'b1);
        rd(ad_cs, v);
        `CHK(v, 8'h41);
        rd(ma(0, `SCCA_MOD_VHIGH), v);
        `CHK(v, 8'h00);
        rd(ma(0, `SCCA_MOD_VLOW), c1);
        `CHK(c1 != 8'h00, 1'b1);
        wr(ma(0, `SCCA_MOD_MODE), 8'h31);
        i_scca_pin_model.set_pin(0, 1'b1);
        repeat (40) @(posedge clk);
        rd(ma(0, `SCCA_MOD_VLOW), v);
        `CHK(v > c1, 1'b1);
        rd(ad_cs, v);
        `CHK(v, 8'h41);
        wr(ad_cs, 8'h00);
    endtask
    task automatic t_tmr();
        logic [7:0] v;
        wr(ma(1, `SCCA_MOD_MODE), 8'h49);
        wr(ma(1, `SCCA_MOD_VLOW), 8'h40);
        rd(ma(1, `SCCA_MOD_MODE), v);
        `CHK(v, 8'h09);
        wr(ma(1, `SCCA_MOD_VHIGH), 8'h00);
        rd(ma(1, `SCCA_MOD_MODE), v);
        `CHK(v, 8'h49);
        wr(ad_cl, 8'h00);
        wr(ad_cs, 8'h40);
        wait_on(5, 1'b1);
        rd(ad_cs, v);
        `CHK(v, 8'h42);
        rd(ad_cl, v);
        `CHK(v >= 8'h40, 1'b1);
        wr(ma(1, `SCCA_MOD_MODE), 8'h00);
        wr(ad_cs, 8'h00);
    endtask
    task automatic t_out();
        logic [7:0] v;
        logic [7:0] cfg [9];
        cfg = '{8'h4C, 8'h30, 8'h00, 8'h42, 8'h80, 8'h80, 8'h48, 8'hA0, 8'h00};
        for (int i = 0; i < 9; i++) begin
            wr(ma(2 + i / 3, 12'(4 * (i % 3))), cfg[i]);
        end
        wr(ad_mc, 8'h42);
        wr(ad_cl, 8'h00);
        wr(ad_cs, 8'h40);
        wait_on(2, 1'b0);
        `CHK(pins_o[3], 1'b0);
        rd(ad_cs, v);
        `CHK(v, 8'h44);
        wait_on(3, 1'b1);
        rd(ad_cl, v);
        `CHK(v >= 8'h80, 1'b1);
        wait_on(6, 1'b1);
        wr(ad_cs, 8'h00);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        $display("[FAIL] t=%0t got=%0h exp=%0h", $time, 0, 1);
        test_done();
    end
    initial begin
        rst_n  = 1'b0;
        {psel, penable, pwrite, t0, idle} = 5'h00;
        gate   = 1'b1;
        paddr  = 12'h000;
        pwdata = 32'h00000000;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_rates();
        t_gate();
        t_ovf();
        t_cap();
        t_tmr();
        t_out();
        test_done();
    end
endmodule
`default_nettype wire
